// ### ram_port_defs.vh
// Register offsets, field positions, reset values and timing counts of the RAM test data port.
// Summary of operation
// - Select bits 2:1 choose one of four RAMs.
// - Test enable bit 0 puts RAMs in test.
// - Ready bit 31 low busy, high idle, resets high.
// - Read ready rises at the edge that loads data register.
// - Command bit 0 write starts access, 1 writes.
// - Address is 15-bit dword index, resets zero.
// - Data register holds write data and read result.
// - Tag RAMs are 37 bits, upper five separate.
`ifndef RAM_PORT_DEFS_VH
`define RAM_PORT_DEFS_VH

`define OFS_SELECT        8'h40
`define OFS_COMMAND       8'h44
`define OFS_ADDRESS       8'h48
`define OFS_DATA_LOW      8'h4c
`define OFS_DATA_HIGH     8'h50

`define BIT_READY         31
`define BIT_TEST_EN       0
`define SEL_HI            2
`define SEL_LO            1
`define BIT_CMD_WRITE     0
`define ADDR_W            15
`define HIGH_W            5

`define RAM_FRAME         2'h0
`define RAM_SERIAL        2'h1
`define RAM_TX_TAG        2'h2
`define RAM_RX_TAG        2'h3

`define RST_ADDR          15'h0000
`define RST_DATA          32'h0000_0000
`define RST_HIGH          5'h00

`define ACC_CYCLES        2'h2
`define MEM_DEPTH_W       6

`endif

// ### test_ram.v
// Small single-port test RAM with registered read data.
`timescale 1ns/100ps
module test_ram
#(
    parameter WIDTH  = 32,
    parameter ADDR_W = 6
)
(
    // Clock.
    input  wire              mclk,
    // Access.
    input  wire              en,
    input  wire              we,
    input  wire [ADDR_W-1:0] addr,
    input  wire [WIDTH-1:0]  wdata,
    output reg  [WIDTH-1:0]  rdata_q
);

    reg [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

    always @(posedge mclk)
    begin
        if (en)
        begin
            if (we)
                mem[addr] <= wdata;
            rdata_q <= mem[addr];
        end
    end

endmodule

// ### ram_port_bank.v
// Bank of the four test-accessible RAMs, steered by the target select.
`timescale 1ns/100ps
`include "ram_port_defs.vh"
module ram_port_bank
(
    // Clock.
    input  wire                  mclk,
    // Access request.
    input  wire                  req,
    input  wire                  we,
    input  wire [1:0]            sel,
    input  wire [`ADDR_W-1:0]    addr,
    input  wire [36:0]           wdata,
    // Read result of the selected RAM.
    output wire [36:0]           rdata
);

    wire [36:0] rd [0:3];
    reg  [1:0]  sel_q;

    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1)
        begin : g_ram
            localparam W = (i >= 2) ? 37 : 32;
            wire [W-1:0] q;
            test_ram #(.WIDTH(W), .ADDR_W(`MEM_DEPTH_W)) u_ram
            (
                .mclk    (mclk),
                .en      (req && (sel == i)),
                .we      (we),
                .addr    (addr[`MEM_DEPTH_W-1:0]),
                .wdata   (wdata[W-1:0]),
                .rdata_q (q)
            );
            if (W == 37)
            begin : g_wide
                assign rd[i] = q;
            end
            else
            begin : g_narrow
                assign rd[i] = {5'h00, q};
            end
        end
    endgenerate

    always @(posedge mclk)
    begin
        if (req)
            sel_q <= sel;
    end

    assign rdata = rd[sel_q];

endmodule

// ### ram_port.v
// Avalon-MM register slave and sequencer of the internal RAM test data port.
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "ram_port_defs.vh"
module ram_port
(
    // Clock and reset.
    input  wire        mclk,
    input  wire        rst_b,
    // Avalon-MM slave.
    input  wire [7:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [3:0]  byteenable,
    input  wire [31:0] writedata,
    output reg  [31:0] readdata,
    output reg         waitrequest,
    // Test mode to the RAMs.
    output reg         ram_test_mode
);

    // Sequencer states.
    localparam ST_IDLE = 2'h0;
    localparam ST_RUN  = 2'h1;
    localparam ST_DONE = 2'h2;

    // Bus handshake.
    reg                ack_q;
    reg                waitrequest_d;
    reg [31:0]         readdata_d;
    reg                ram_test_mode_d;

    // Software visible registers.
    reg                test_en_q;
    reg                test_en_d;
    reg [1:0]          ram_target_select_q;
    reg [1:0]          ram_target_select_d;
    reg [`ADDR_W-1:0]  addr_q;
    reg [`ADDR_W-1:0]  addr_d;
    reg [31:0]         data_low_q;
    reg [31:0]         data_low_d;
    reg [`HIGH_W-1:0]  data_high_q;
    reg [`HIGH_W-1:0]  data_high_d;
    reg                cmd_write_q;
    reg                cmd_write_d;
    reg                port_ready_flag_q;
    reg                port_ready_flag_d;

    // Access sequencer.
    reg [1:0]          st_q;
    reg [1:0]          st_d;
    reg [1:0]          cnt_q;
    reg [1:0]          cnt_d;
    reg                req_q;
    reg                req_d;

    // Read result of the selected RAM.
    wire [36:0]        ram_rdata;

    // Reads are decoded in the first cycle so that the data stand when the wait
    // state ends; writes take effect only at the edge that accepts them.
    wire               acc      = (read || write) && !ack_q;
    wire               rd_acc   = read && acc;
    wire               wr_acc   = write && ack_q;
    wire               sel_hit  = wr_acc && (address == `OFS_SELECT);
    wire               cmd_hit  = wr_acc && (address == `OFS_COMMAND) && byteenable[0];
    wire               addr_hit = wr_acc && (address == `OFS_ADDRESS);
    wire               low_hit  = wr_acc && (address == `OFS_DATA_LOW);
    wire               high_hit = wr_acc && (address == `OFS_DATA_HIGH);

    // Merges byte lanes of a write into an old value.
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  be;
        integer k;
        begin
            merge = old;
            for (k = 0; k < 4; k = k + 1)
                if (be[k])
                    merge[k*8 +: 8] = nw[k*8 +: 8];
        end
    endfunction

    wire [31:0] sel_m  = merge({29'h0, ram_target_select_q, test_en_q}, writedata, byteenable);
    wire [31:0] addr_m = merge({17'h0, addr_q}, writedata, byteenable);
    wire [31:0] low_m  = merge(data_low_q, writedata, byteenable);
    wire [31:0] high_m = merge({27'h0, data_high_q}, writedata, byteenable);

    ram_port_bank u_bank
    (
        .mclk  (mclk),
        .req   (req_q),
        .we    (cmd_write_q),
        .sel   (ram_target_select_q),
        .addr  (addr_q),
        .wdata ({data_high_q, data_low_q}),
        .rdata (ram_rdata)
    );

    // Waitrequest is low only in the second cycle of each access.
    always @*
    begin
        waitrequest_d   = !acc;
        ram_test_mode_d = test_en_q;
        readdata_d      = readdata;
        if (rd_acc)
        begin
            case (address)
                `OFS_SELECT:    readdata_d = {port_ready_flag_q, 28'h0,
                                              ram_target_select_q, test_en_q};
                `OFS_COMMAND:   readdata_d = {31'h0, cmd_write_q};
                `OFS_ADDRESS:   readdata_d = {17'h0, addr_q};
                `OFS_DATA_LOW:  readdata_d = data_low_q;
                `OFS_DATA_HIGH: readdata_d = {27'h0, data_high_q};
                default:        readdata_d = 32'h0000_0000;
            endcase
        end
    end

    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ack_q         <= 1'b0;
            waitrequest   <= 1'b1;
            readdata      <= 32'h0000_0000;
            ram_test_mode <= 1'b0;
        end
        else
        begin
            ack_q         <= acc;
            waitrequest   <= waitrequest_d;
            readdata      <= readdata_d;
            ram_test_mode <= ram_test_mode_d;
        end
    end

    always @*
    begin
        test_en_d           = test_en_q;
        ram_target_select_d = ram_target_select_q;
        addr_d              = addr_q;
        if (sel_hit)
        begin
            test_en_d           = sel_m[`BIT_TEST_EN];
            ram_target_select_d = sel_m[`SEL_HI:`SEL_LO];
        end
        if (addr_hit)
        begin
            addr_d = addr_m[`ADDR_W-1:0];
        end
    end

    // A read result overrides a software data write in the same cycle.
    always @*
    begin
        st_d              = st_q;
        cnt_d             = cnt_q;
        req_d             = 1'b0;
        cmd_write_d       = cmd_write_q;
        port_ready_flag_d = port_ready_flag_q;
        data_low_d        = data_low_q;
        data_high_d       = data_high_q;
        if (low_hit)
        begin
            data_low_d = low_m;
        end
        if (high_hit)
        begin
            data_high_d = high_m[`HIGH_W-1:0];
        end
        case (st_q)
            ST_IDLE:
            begin
                // A command that arrives while busy is dropped.
                if (cmd_hit)
                begin
                    cmd_write_d       = writedata[`BIT_CMD_WRITE];
                    port_ready_flag_d = 1'b0;
                    req_d             = 1'b1;
                    cnt_d             = `ACC_CYCLES;
                    st_d              = ST_RUN;
                end
            end
            ST_RUN:
            begin
                if (cnt_q == 2'h0)
                begin
                    st_d = ST_DONE;
                end
                else
                begin
                    cnt_d = cnt_q - 2'h1;
                end
            end
            ST_DONE:
            begin
                if (!cmd_write_q)
                begin
                    data_low_d  = ram_rdata[31:0];
                    data_high_d = ram_rdata[36:32];
                end
                port_ready_flag_d = 1'b1;
                st_d              = ST_IDLE;
            end
            default:
            begin
                st_d = ST_IDLE;
            end
        endcase
    end

    // Software visible registers.
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            test_en_q           <= 1'b0;
            ram_target_select_q <= `RAM_FRAME;
        end
        else
        begin
            test_en_q           <= test_en_d;
            ram_target_select_q <= ram_target_select_d;
        end
    end

    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            addr_q <= `RST_ADDR;
        end
        else
        begin
            addr_q <= addr_d;
        end
    end

    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            data_low_q <= `RST_DATA;
        end
        else
        begin
            data_low_q <= data_low_d;
        end
    end

    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            data_high_q <= `RST_HIGH;
        end
        else
        begin
            data_high_q <= data_high_d;
        end
    end

    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cmd_write_q <= 1'b0;
        end
        else
        begin
            cmd_write_q <= cmd_write_d;
        end
    end

    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            port_ready_flag_q <= 1'b1;
        end
        else
        begin
            port_ready_flag_q <= port_ready_flag_d;
        end
    end

    // Access sequencer.
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q  <= ST_IDLE;
            cnt_q <= 2'h0;
            req_q <= 1'b0;
        end
        else
        begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            req_q <= req_d;
        end
    end

endmodule

// ### ram_port_chk.sv
// Checker of the RAM test data port register behaviour.
`timescale 1ns/100ps
module ram_port_chk
(
    // Clock, reset and bus.
    input wire        mclk,
    input wire        rst_b,
    input wire [7:0]  address,
    input wire        read,
    input wire        write,
    input wire [3:0]  byteenable,
    input wire [31:0] writedata,
    input wire [31:0] readdata,
    input wire        waitrequest,
    input wire        ram_test_mode
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    wire        rd_a = read && !waitrequest;
    wire        wr_a = write && !waitrequest && (&byteenable);
    reg  [2:0]  sel_q;
    reg  [14:0] addr_q;
    reg  [31:0] data_q;
    reg         cmd_q;
    reg         seen_q;
    reg         dirty_q;
    // Shadow copies of what software last wrote.
    always @(posedge mclk or negedge rst_b)
        if (!rst_b)
        begin
            sel_q <= 3'h0;
            addr_q <= 15'h0000;
            data_q <= 32'h0000_0000;
            cmd_q <= 1'b0;
            seen_q <= 1'b0;
            dirty_q <= 1'b0;
        end
        else if (wr_a)
        begin
            sel_q <= (address == 8'h40) ? writedata[2:0] : sel_q;
            addr_q <= (address == 8'h48) ? writedata[14:0] : addr_q;
            data_q <= (address == 8'h4c) ? writedata : data_q;
            cmd_q <= (address == 8'h44) ? writedata[0] : cmd_q;
            seen_q <= seen_q | (address == 8'h44);
            dirty_q <= (address == 8'h44) | (dirty_q & (address != 8'h4c));
        end
    a_sel_readback: assert property (rd_a && address == 8'h40 |-> readdata[2:0] == sel_q)
        else $error("select readback wrong");
    a_test_mode: assert property (wr_a && address == 8'h40
        |-> ##2 ram_test_mode == $past(writedata[0], 2))
        else $error("test mode not following enable");
    a_ready_reset: assert property (rd_a && address == 8'h40 && !seen_q
        |-> readdata[31] && readdata[30:3] == 28'h0)
        else $error("ready not set after reset");
    a_cmd_readback: assert property (rd_a && address == 8'h44
        |-> readdata == {31'h0, cmd_q})
        else $error("command readback wrong");
    a_addr_width: assert property (rd_a && address == 8'h48
        |-> readdata == {17'h0, addr_q})
        else $error("address readback wrong");
    a_data_hold: assert property (rd_a && address == 8'h4c && !dirty_q
        |-> readdata == data_q)
        else $error("data register readback wrong");
    a_high_width: assert property (rd_a && address == 8'h50
        |-> readdata[31:5] == 27'h0)
        else $error("high data reserved bits set");
    a_wait_first: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
        else $error("access not taken after one wait cycle");
    c_cmd_write: cover property (wr_a && address == 8'h44 && writedata[0]);
    c_cmd_read: cover property (wr_a && address == 8'h44 && !writedata[0]);
    c_busy_seen: cover property (rd_a && address == 8'h40 && !readdata[31]);
endmodule
bind ram_port ram_port_chk i_ram_port_chk (.mclk, .rst_b, .address, .read, .write,
    .byteenable, .writedata, .readdata, .waitrequest, .ram_test_mode);

// ### ram_port_tb_top.sv
// Self-checking bench of the RAM test data port.
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module ram_port_tb_top;
    reg         mclk = 1'b0;
    reg         rst_b = 1'b0;
    reg  [7:0]  address = 8'h00;
    reg         read = 1'b0;
    reg         write = 1'b0;
    reg  [3:0]  byteenable = 4'hf;
    reg  [31:0] writedata = 32'h0000_0000;
    wire [31:0] readdata;
    wire        waitrequest;
    wire        ram_test_mode;
    int         n_mismatch = 0;
    int         n_tests = 0;
    reg  [31:0] rd;
    ram_port i_ram_port (.mclk, .rst_b, .address, .read, .write, .byteenable,
        .writedata, .readdata, .waitrequest, .ram_test_mode);
    always #5 mclk = ~mclk;
    // One Avalon access, held until waitrequest is sampled low at a rising edge.
    task automatic bus(input bit w, input [7:0] a, input [31:0] d);
        @(posedge mclk);
        address <= a;
        writedata <= d;
        read <= !w;
        write <= w;
        @(posedge mclk);
        while (waitrequest !== 1'b0)
            @(posedge mclk);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic poll();
        bus(0, 8'h40, 0);
        `CHK("busy", 1'b0, rd[31])
        repeat (30)
        begin
            bus(0, 8'h40, 0);
            if (rd[31] === 1'b1) break;
        end
        `CHK("ready", 1'b1, rd[31])
    endtask
    task automatic t_reset();
        `CHK("test mode off", 1'b0, ram_test_mode)
        for (int i = 0; i < 5; i++)
        begin
            bus(0, 8'h40 + 8'(4 * i), 0);
            `CHK("reset value", (i == 0) ? 32'h8000_0000 : 32'h0, rd)
        end
        bus(1, 8'h48, 32'hffff_ffff);
        bus(0, 8'h48, 0);
        `CHK("address", 32'h0000_7fff, rd)
    endtask
    task automatic t_rams();
        for (int s = 0; s < 4; s++)
        begin
            bus(1, 8'h40, {29'h0, 2'(s), 1'b1});
            bus(1, 8'h48, 32'h0000_0005);
            bus(1, 8'h4c, 32'h1234_5670 + s);
            bus(0, 8'h4c, 0);
            `CHK("data written", 32'h1234_5670 + s, rd)
            bus(1, 8'h50, 32'h0000_0011 + s);
            bus(1, 8'h44, 32'h0000_0001);
            poll();
            bus(0, 8'h44, 0);
            `CHK("write command", 32'h1, rd)
        end
        `CHK("test mode", 1'b1, ram_test_mode)
        for (int s = 0; s < 4; s++)
        begin
            bus(1, 8'h40, {29'h0, 2'(s), 1'b1});
            bus(0, 8'h40, 0);
            `CHK("select", {2'(s), 1'b1}, rd[2:0])
            bus(1, 8'h4c, 32'h0);
            bus(1, 8'h44, 32'h0);
            poll();
            bus(0, 8'h4c, 0);
            `CHK("data low", 32'h1234_5670 + s, rd)
            bus(0, 8'h50, 0);
            `CHK("data high", (s > 1) ? 32'h11 + s : 32'h0, rd)
            bus(0, 8'h44, 0);
            `CHK("command", 32'h0, rd)
        end
    endtask
    // A reset in mid-run brings every register back to its default.
    task automatic t_mid_reset();
        @(posedge mclk);
        rst_b <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        t_reset();
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        #100000;
        n_mismatch++;
        end_of_test();
    end
    initial
    begin
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        t_reset();
        t_rams();
        t_mid_reset();
        end_of_test();
    end
endmodule
